// [logic/mbag_map.svh]
// Register offsets, field positions and reset values of the address generator
// Assumes a 32-bit APB slave with byte addresses, one aligned word per register
`ifndef MBAG_MAP_SVH
`define MBAG_MAP_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define MBAG_ADDR_W          8
`define MBAG_OFS_CTRL        8'h00
`define MBAG_OFS_PIVOT       8'h04
`define MBAG_OFS_X_START     8'h08
`define MBAG_OFS_X_END       8'h0C
`define MBAG_OFS_Y_START     8'h10
`define MBAG_OFS_Y_END       8'h14
`define MBAG_OFS_STATUS      8'h18
`define MBAG_OFS_WRAP_CNT    8'h1C

// ****************************************************************
// Field positions
// ****************************************************************
`define MBAG_CTRL_XSEL_LSB   0
`define MBAG_CTRL_YSEL_LSB   4
`define MBAG_CTRL_BSEL_LSB   8
`define MBAG_CTRL_YEN_BIT    14
`define MBAG_CTRL_XEN_BIT    15
`define MBAG_PIVOT_EN_BIT    15
`define MBAG_SEL_OFF         4'hF

// ****************************************************************
// Reset values
// ****************************************************************
`define MBAG_CTRL_RST        16'h0FFF
`define MBAG_PIVOT_RST       16'h0000
`define MBAG_BOUND_RST       16'h0000

`endif

// [logic/mbag_pkg.sv]
// Types shared by the address generator and its modulo unit
// Assumes the decoder supplies one request per generator per cycle
package mbag_pkg;

	// Addressing mode of one operand access
	typedef enum logic [2:0] {
		MBAG_INDIRECT,
		MBAG_POST_INC,
		MBAG_POST_DEC,
		MBAG_PRE_INC,
		MBAG_PRE_DEC,
		MBAG_REG_OFFSET,
		MBAG_LIT_OFFSET
	} mbag_mode_type;

	// Request from the instruction decoder
	typedef struct packed {
		logic          valid;
		logic [3:0]    wreg;
		logic [15:0]   ptr;
		mbag_mode_type mode;
		logic [15:0]   delta;
		logic          byte_sel;
	} mbag_req_type;

	// Answer towards data memory and the register file
	typedef struct packed {
		logic        valid;
		logic [15:0] ea;
		logic        wb_en;
		logic [3:0]  wb_reg;
		logic [15:0] wb_val;
		logic        wrapped;
		logic        bitrev;
	} mbag_res_type;

endpackage

// [logic/mbag_agen.sv]
// One address generator with circular buffer correction
// Assumes a signed delta; pure combinational, the caller registers the result
`timescale 1ns/1ps
`default_nettype none

module mbag_agen
	import mbag_pkg::*;
(
	// Request
	input  wire mbag_pkg::mbag_req_type req_in,
	// Configuration
	input  wire logic                   mod_on_in,
	input  wire logic [3:0]             sel_in,
	input  wire logic [15:0]            start_in,
	input  wire logic [15:0]            end_in,
	input  wire logic                   word_in,
	// Result
	output mbag_pkg::mbag_res_type      res_out
);

	logic        hit;
	logic [15:0] eff_delta;
	logic [15:0] sum;
	logic [15:0] len;
	logic        over;
	logic        under;
	logic [15:0] corr;
	logic        pre_use;
	logic        is_mod;

	// Any selected working register may be corrected
	assign hit       = mod_on_in && (req_in.wreg == sel_in);
	assign eff_delta = (req_in.mode == MBAG_INDIRECT) ? 16'h0000 : req_in.delta;
	assign sum       = req_in.ptr + eff_delta;
	assign len       = end_in - start_in + 16'h0001;
	// Beyond, not just equal, so large steps still wrap
	assign over      = !eff_delta[15] && (sum > end_in);
	assign under     = eff_delta[15] && (sum < start_in);

	always_comb
	begin
		corr = sum;
		if (hit && over)
		begin
			corr = sum - len;
		end
		else if (hit && under)
		begin
			corr = sum + len;
		end
	end

	assign pre_use = (req_in.mode == MBAG_PRE_INC) || (req_in.mode == MBAG_PRE_DEC)
		|| (req_in.mode == MBAG_REG_OFFSET) || (req_in.mode == MBAG_LIT_OFFSET);
	assign is_mod  = (req_in.mode == MBAG_PRE_INC) || (req_in.mode == MBAG_PRE_DEC)
		|| (req_in.mode == MBAG_POST_INC) || (req_in.mode == MBAG_POST_DEC);

	always_comb
	begin
		res_out         = '0;
		res_out.valid   = req_in.valid;
		res_out.ea      = pre_use ? corr : req_in.ptr;
		// Offset modes correct the address but leave the register
		res_out.wb_en   = req_in.valid && is_mod;
		res_out.wb_reg  = req_in.wreg;
		res_out.wb_val  = corr;
		res_out.wrapped = req_in.valid && hit && (over || under);
		if (hit && word_in)
		begin
			res_out.ea[0]     = 1'b0;
			res_out.wb_val[0] = 1'b0;
		end
	end

endmodule

`default_nettype wire

// [logic/mbag_top.sv]
// Modulo address generation for X read, X write and Y, bit-reversed for X write
// Assumes requests come from same-clock decode logic; APB slave, zero wait
`timescale 1ns/1ps
`default_nettype none
`include "mbag_map.svh"

module mbag_top
(
	// Clock and reset
	input  wire logic                   CLK_IN,
	input  wire logic                   ARST_N_IN,
	// APB slave
	input  wire logic                   PSEL_IN,
	input  wire logic                   PENABLE_IN,
	input  wire logic                   PWRITE_IN,
	input  wire logic [31:0]            PADDR_IN,
	input  wire logic [31:0]            PWDATA_IN,
	output var  logic [31:0]            PRDATA_OUT,
	output var  logic                   PREADY_OUT,
	output var  logic                   PSLVERR_OUT,
	// Decoder requests
	input  wire mbag_pkg::mbag_req_type XR_REQ_IN,
	input  wire mbag_pkg::mbag_req_type XW_REQ_IN,
	input  wire mbag_pkg::mbag_req_type Y_REQ_IN,
	// Generated addresses
	output mbag_pkg::mbag_res_type      XR_RES_OUT,
	output mbag_pkg::mbag_res_type      XW_RES_OUT,
	output mbag_pkg::mbag_res_type      Y_RES_OUT
);

	import mbag_pkg::*;

	// ****************************************************************
	// Reset release
	// ****************************************************************
	logic        rst_meta_ff;
	logic        rst_n_ff;

	always_ff @(posedge CLK_IN or negedge ARST_N_IN)
	begin
		if (!ARST_N_IN)
		begin
			rst_meta_ff <= 1'b0;
			rst_n_ff    <= 1'b0;
		end
		else
		begin
			rst_meta_ff <= 1'b1;
			rst_n_ff    <= rst_meta_ff;
		end
	end

	// ****************************************************************
	// Registers
	// ****************************************************************
	logic [15:0] ctrl_ff;
	logic [15:0] pivot_ff;
	logic [15:0] x_start_ff;
	logic [15:0] x_end_ff;
	logic [15:0] y_start_ff;
	logic [15:0] y_end_ff;
	logic [15:0] wrap_cnt_ff;
	logic [31:0] rdata_ff;
	logic        err_ff;

	logic [7:0]  addr;
	logic        setup;
	logic        wr_acc;
	logic        mapped;
	logic [31:0] nxt_rdata;
	logic [3:0]  status;

	assign addr   = PADDR_IN[7:0];
	assign setup  = PSEL_IN && !PENABLE_IN;
	assign wr_acc = PSEL_IN && PENABLE_IN && PWRITE_IN && !err_ff;
	assign mapped = (PADDR_IN[31:8] == 24'h000000) && (addr[1:0] == 2'b00)
		&& (addr <= `MBAG_OFS_WRAP_CNT);

	always_ff @(posedge CLK_IN or negedge rst_n_ff)
	begin
		if (!rst_n_ff)
		begin
			ctrl_ff    <= `MBAG_CTRL_RST;
			pivot_ff   <= `MBAG_PIVOT_RST;
			x_start_ff <= `MBAG_BOUND_RST;
			x_end_ff   <= `MBAG_BOUND_RST;
			y_start_ff <= `MBAG_BOUND_RST;
			y_end_ff   <= `MBAG_BOUND_RST;
		end
		else if (wr_acc)
		begin
			unique case (addr)
				`MBAG_OFS_CTRL:    ctrl_ff    <= PWDATA_IN[15:0];
				`MBAG_OFS_PIVOT:   pivot_ff   <= PWDATA_IN[15:0];
				`MBAG_OFS_X_START: x_start_ff <= PWDATA_IN[15:0];
				`MBAG_OFS_X_END:   x_end_ff   <= PWDATA_IN[15:0];
				`MBAG_OFS_Y_START: y_start_ff <= PWDATA_IN[15:0];
				`MBAG_OFS_Y_END:   y_end_ff   <= PWDATA_IN[15:0];
				default:
				begin
				end
			endcase
		end
	end

	// Read data sampled in setup so it leaves a flip-flop
	always_comb
	begin
		nxt_rdata = 32'h00000000;
		unique case (addr)
			`MBAG_OFS_CTRL:     nxt_rdata[15:0] = ctrl_ff;
			`MBAG_OFS_PIVOT:    nxt_rdata[15:0] = pivot_ff;
			`MBAG_OFS_X_START:  nxt_rdata[15:0] = x_start_ff;
			`MBAG_OFS_X_END:    nxt_rdata[15:0] = x_end_ff;
			`MBAG_OFS_Y_START:  nxt_rdata[15:0] = y_start_ff;
			`MBAG_OFS_Y_END:    nxt_rdata[15:0] = y_end_ff;
			`MBAG_OFS_STATUS:   nxt_rdata[3:0]  = status;
			`MBAG_OFS_WRAP_CNT: nxt_rdata[15:0] = wrap_cnt_ff;
			default:            nxt_rdata = 32'h00000000;
		endcase
	end

	always_ff @(posedge CLK_IN or negedge rst_n_ff)
	begin
		if (!rst_n_ff)
		begin
			rdata_ff <= 32'h00000000;
			err_ff   <= 1'b0;
		end
		else if (setup)
		begin
			rdata_ff <= mapped ? nxt_rdata : 32'h00000000;
			err_ff   <= !mapped;
		end
	end

	assign PRDATA_OUT  = rdata_ff;
	assign PREADY_OUT  = 1'b1;
	assign PSLVERR_OUT = PSEL_IN && PENABLE_IN && err_ff;

	// ****************************************************************
	// Enables
	// ****************************************************************
	logic [3:0]  x_sel;
	logic [3:0]  y_sel;
	logic [3:0]  b_sel;
	logic        x_mod_on;
	logic        y_mod_on;
	logic        brev_on;
	logic        brev_act;
	logic        xw_incr;

	assign x_sel    = ctrl_ff[`MBAG_CTRL_XSEL_LSB +: 4];
	assign y_sel    = ctrl_ff[`MBAG_CTRL_YSEL_LSB +: 4];
	assign b_sel    = ctrl_ff[`MBAG_CTRL_BSEL_LSB +: 4];
	assign x_mod_on = (x_sel != `MBAG_SEL_OFF) && ctrl_ff[`MBAG_CTRL_XEN_BIT];
	assign y_mod_on = (y_sel != `MBAG_SEL_OFF) && ctrl_ff[`MBAG_CTRL_YEN_BIT];
	assign brev_on  = (b_sel != `MBAG_SEL_OFF) && pivot_ff[`MBAG_PIVOT_EN_BIT];
	assign xw_incr  = (XW_REQ_IN.mode == MBAG_PRE_INC) || (XW_REQ_IN.mode == MBAG_POST_INC);
	// Bytes and other modes fall back to normal addressing
	assign brev_act = brev_on && xw_incr && !XW_REQ_IN.byte_sel
		&& (XW_REQ_IN.wreg == b_sel);

	// ****************************************************************
	// Modulo generators
	// ****************************************************************
	mbag_res_type xr_res;
	mbag_res_type xw_res;
	mbag_res_type y_res;

	mbag_agen u_xr
	(
		.req_in    (XR_REQ_IN),
		.mod_on_in (x_mod_on),
		.sel_in    (x_sel),
		.start_in  (x_start_ff),
		.end_in    (x_end_ff),
		.word_in   (1'b0),
		.res_out   (xr_res)
	);

	// Reversal switches modulo off here, read side keeps it
	mbag_agen u_xw
	(
		.req_in    (XW_REQ_IN),
		.mod_on_in (x_mod_on && !brev_act),
		.sel_in    (x_sel),
		.start_in  (x_start_ff),
		.end_in    (x_end_ff),
		.word_in   (1'b0),
		.res_out   (xw_res)
	);

	mbag_agen u_y
	(
		.req_in    (Y_REQ_IN),
		.mod_on_in (y_mod_on),
		.sel_in    (y_sel),
		.start_in  (y_start_ff),
		.end_in    (y_end_ff),
		.word_in   (1'b1),
		.res_out   (y_res)
	);

	// ****************************************************************
	// Bit-reversed update
	// ****************************************************************
	function automatic logic [15:0] mirror16(input logic [15:0] v);
		logic [15:0] r;
		r = 16'h0000;
		for (int i = 0; i < 16; i++)
		begin
			r[i] = v[15 - i];
		end
		return r;
	endfunction

	logic [15:0] piv_bytes;
	logic [15:0] ptr_word;
	logic [15:0] brev_next;
	mbag_res_type xw_final;

	// Word data: pointer LSB dropped, pivot scaled to bytes
	assign piv_bytes = {pivot_ff[14:0], 1'b0};
	assign ptr_word  = {XW_REQ_IN.ptr[15:1], 1'b0};
	// Carry runs downwards; valid only for an aligned buffer start
	// Carry into bit 0 is dropped, word data keeps the LSB clear
	assign brev_next = mirror16(mirror16(ptr_word) + mirror16(piv_bytes))
		& 16'hFFFE;

	always_comb
	begin
		xw_final = xw_res;
		if (brev_act)
		begin
			xw_final.ea      = (XW_REQ_IN.mode == MBAG_PRE_INC) ? brev_next : ptr_word;
			xw_final.wb_val  = brev_next;
			xw_final.wb_en   = XW_REQ_IN.valid;
			xw_final.wrapped = 1'b0;
			xw_final.bitrev  = XW_REQ_IN.valid;
		end
	end

	// ****************************************************************
	// Result registers and status
	// ****************************************************************
	always_ff @(posedge CLK_IN or negedge rst_n_ff)
	begin
		if (!rst_n_ff)
		begin
			XR_RES_OUT <= '0;
			XW_RES_OUT <= '0;
			Y_RES_OUT  <= '0;
		end
		else
		begin
			XR_RES_OUT <= xr_res;
			XW_RES_OUT <= xw_final;
			Y_RES_OUT  <= y_res;
		end
	end

	assign status = {XW_RES_OUT.bitrev, Y_RES_OUT.wrapped, XW_RES_OUT.wrapped,
		XR_RES_OUT.wrapped};

	// Counter saturates; a write of any value clears it, and a wrap in the same cycle counts from zero
	logic [1:0]  wrap_inc;

	assign wrap_inc = 2'(xr_res.wrapped) + 2'(xw_final.wrapped) + 2'(y_res.wrapped);

	always_ff @(posedge CLK_IN or negedge rst_n_ff)
	begin
		if (!rst_n_ff)
		begin
			wrap_cnt_ff <= 16'h0000;
		end
		else if (wrap_inc != 2'b00)
		begin
			if (wr_acc && (addr == `MBAG_OFS_WRAP_CNT))
			begin
				wrap_cnt_ff <= {14'h0000, wrap_inc};
			end
			else if (wrap_cnt_ff <= (16'hFFFF - {14'h0000, wrap_inc}))
			begin
				wrap_cnt_ff <= wrap_cnt_ff + {14'h0000, wrap_inc};
			end
			else
			begin
				wrap_cnt_ff <= 16'hFFFF;
			end
		end
		else if (wr_acc && (addr == `MBAG_OFS_WRAP_CNT))
		begin
			wrap_cnt_ff <= 16'h0000;
		end
	end

endmodule

`default_nettype wire

// [tb/mbag_chk_asserts.sv]
// Port checker for the modulo and bit-reversed address generator
// Assumes a bind to mbag_top; control register at byte offset 0
`timescale 1ns/1ps
`default_nettype none

module mbag_chk
	import mbag_pkg::*;
(
	// Clock, reset and APB
	input wire logic                   CLK_IN,
	input wire logic                   ARST_N_IN,
	input wire logic                   PSEL_IN,
	input wire logic                   PENABLE_IN,
	input wire logic                   PWRITE_IN,
	input wire logic [31:0]            PADDR_IN,
	input wire logic [31:0]            PWDATA_IN,
	// Generators
	input wire mbag_pkg::mbag_req_type XR_REQ_IN,
	input wire mbag_pkg::mbag_req_type XW_REQ_IN,
	input wire mbag_pkg::mbag_res_type XR_RES_OUT,
	input wire mbag_pkg::mbag_res_type XW_RES_OUT,
	input wire mbag_pkg::mbag_res_type Y_RES_OUT
);
	logic [15:0] ctrl_ff;

	default clocking @(posedge CLK_IN);
	endclocking
	default disable iff (!ARST_N_IN);

	// Shadow of control, lands on the same edge as the real write
	always_ff @(posedge CLK_IN or negedge ARST_N_IN)
	begin
		if (!ARST_N_IN)
			ctrl_ff <= 16'h0FFF;
		else if (PSEL_IN && PENABLE_IN && PWRITE_IN && PADDR_IN == 32'h0)
			ctrl_ff <= PWDATA_IN[15:0];
	end

	chk_x_off_both:
		assert property (ctrl_ff[3:0] == 4'hF |=> !XR_RES_OUT.wrapped && !XW_RES_OUT.wrapped)
		else $error("x wrap while select off");
	chk_x_en_need:
		assert property (!ctrl_ff[15] |=> !XR_RES_OUT.wrapped)
		else $error("x wrap while disabled");
	chk_y_en_need:
		assert property (!ctrl_ff[14] |=> !Y_RES_OUT.wrapped)
		else $error("y wrap while disabled");
	chk_y_off_sel:
		assert property (ctrl_ff[7:4] == 4'hF |=> !Y_RES_OUT.wrapped)
		else $error("y wrap while select off");
	chk_wb_mode:
		assert property (XR_REQ_IN.mode inside {MBAG_INDIRECT, MBAG_REG_OFFSET,
			MBAG_LIT_OFFSET} |=> !XR_RES_OUT.wb_en)
		else $error("write back on offset mode");
	chk_rev_xw_only:
		assert property (!XR_RES_OUT.bitrev && !Y_RES_OUT.bitrev)
		else $error("reversal outside x write");
	chk_rev_byte:
		assert property (XW_REQ_IN.byte_sel || !(XW_REQ_IN.mode inside {MBAG_PRE_INC,
			MBAG_POST_INC}) |=> !XW_RES_OUT.bitrev)
		else $error("reversal on byte or other mode");
	chk_rev_word:
		assert property (XW_RES_OUT.bitrev |-> !XW_RES_OUT.ea[0] && !XW_RES_OUT.wb_val[0])
		else $error("reversed address odd");
	chk_rev_nomod:
		assert property (XW_RES_OUT.bitrev |-> !XW_RES_OUT.wrapped)
		else $error("modulo beside reversal");
endmodule

bind mbag_top mbag_chk chk_u (
	.CLK_IN(CLK_IN), .ARST_N_IN(ARST_N_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN),
	.PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN), .PWDATA_IN(PWDATA_IN),
	.XR_REQ_IN(XR_REQ_IN), .XW_REQ_IN(XW_REQ_IN), .XR_RES_OUT(XR_RES_OUT),
	.XW_RES_OUT(XW_RES_OUT), .Y_RES_OUT(Y_RES_OUT)
);
`default_nettype wire

// [tb/mbag_rf_model.sv]
// Working register file beside the address generator
// Assumes one result per generator per cycle; Y wins a same-cycle clash
`timescale 1ns/1ps
`default_nettype none

module mbag_rf_model
	import mbag_pkg::*;
(
	// Clock and reset
	input  wire logic                   clk_in,
	input  wire logic                   rst_n_in,
	// Write-back from the generators
	input  wire mbag_pkg::mbag_res_type xw_in,
	input  wire mbag_pkg::mbag_res_type y_in,
	// Pointers towards the decoder
	output logic [15:0][15:0]           regs_out
);
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			regs_out <= '0;
		else
		begin
			if (xw_in.valid && xw_in.wb_en)
				regs_out[xw_in.wb_reg] <= xw_in.wb_val;
			if (y_in.valid && y_in.wb_en)
				regs_out[y_in.wb_reg] <= y_in.wb_val;
		end
	end
endmodule
`default_nettype wire

// [tb/test_modulo_bitrev_address_gen.sv]
// Self-checking bench for the modulo and bit-reversed address generator
// Assumes a zero-wait APB slave and one-cycle generator results
`timescale 1ns/1ps
`default_nettype none

module test_modulo_bitrev_address_gen;
	import mbag_pkg::*;

	logic              clk, rst_n, psel, pena, pwr, pready, perr, er;
	logic [31:0]       paddr, pwdata, prdata, rd;
	mbag_req_type      xr, xw, yq, q0, q1, q2;
	mbag_res_type      xr_o, xw_o, y_o, e0, e1, e2;
	logic [15:0]       ctrl, piv, xs, xe, ys, ye;
	logic [15:0]       cfg [6];
	logic [15:0][15:0] regs;
	int                mismatches, checked, cyc, i, k;

	mbag_top dut_u (
		.CLK_IN(clk), .ARST_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(pena),
		.PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
		.PREADY_OUT(pready), .PSLVERR_OUT(perr), .XR_REQ_IN(xr), .XW_REQ_IN(xw),
		.Y_REQ_IN(yq), .XR_RES_OUT(xr_o), .XW_RES_OUT(xw_o), .Y_RES_OUT(y_o)
	);

	mbag_rf_model rf_u (
		.clk_in(clk), .rst_n_in(rst_n), .xw_in(xw_o), .y_in(y_o), .regs_out(regs)
	);

	always #12.5 clk = ~clk;

	always @(posedge clk)
	begin
		cyc++;
		if (cyc > 20000)
		begin
			mismatches++;
			end_sim();
		end
	end

	// ********
	// Helpers
	// ********
	task automatic end_sim();
		if (mismatches == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic cmp(input logic [63:0] s, input logic [63:0] x);
		checked++;
		if (s !== x)
		begin
			mismatches++;
			$display("[FAIL] %0t seen %h expected %h", $time, s, x);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d,
		output logic [31:0] r, output logic e);
		@(posedge clk);
		psel <= 1'b1;
		pena <= 1'b0;
		pwr <= w;
		paddr <= 32'(a);
		pwdata <= 32'(d);
		@(posedge clk);
		pena <= 1'b1;
		do
			@(posedge clk);
		while (pready !== 1'b1);
		r = prdata;
		e = perr;
		psel <= 1'b0;
		pena <= 1'b0;
	endtask

	function automatic logic [15:0] rev16(input logic [15:0] v);
		for (int b = 0; b < 16; b++)
			rev16[b] = v[15 - b];
	endfunction

	function automatic logic [3:0] rsel();
		int r;
		r = $urandom % 4;
		return r == 3 ? 4'hF : 4'(r + 1);
	endfunction

	// Word-sized pointers for Y; offsets reach past either boundary
	function automatic mbag_req_type nq(input logic [15:0] st, input logic y);
		mbag_req_type q;
		q.valid = 1'b1;
		q.wreg = rsel() & 4'h3;
		q.ptr = st - 16'h8 + 16'($urandom % 56);
		q.mode = mbag_mode_type'(3'($urandom % 7));
		q.delta = 16'($urandom % 81) - 16'd40;
		q.byte_sel = ($urandom % 4) == 0;
		if (y)
		begin
			q.ptr[0] = 1'b0;
			q.delta[0] = 1'b0;
		end
		return q;
	endfunction

	function automatic mbag_res_type ex(input mbag_req_type q, input int g);
		mbag_res_type r;
		logic [15:0] s, st, en;
		logic on, br, dn;
		r = '0;
		r.valid = 1'b1;
		r.wb_reg = q.wreg;
		r.wb_en = q.mode inside {MBAG_POST_INC, MBAG_POST_DEC, MBAG_PRE_INC, MBAG_PRE_DEC};
		br = g == 1 && ctrl[11:8] != 4'hF && piv[15] && q.wreg == ctrl[11:8]
			&& q.mode inside {MBAG_PRE_INC, MBAG_POST_INC} && !q.byte_sel;
		on = g == 2 ? ctrl[7:4] != 4'hF && ctrl[14] && q.wreg == ctrl[7:4]
			: ctrl[3:0] != 4'hF && ctrl[15] && q.wreg == ctrl[3:0];
		st = g == 2 ? ys : xs;
		en = g == 2 ? ye : xe;
		s = q.ptr + (q.mode == MBAG_INDIRECT ? 16'h0 : q.delta);
		// Plain indirect uses no step, so it checks as incrementing
		dn = q.mode != MBAG_INDIRECT && q.delta[15];
		r.wrapped = on && !br && (dn ? s < st : s > en);
		if (r.wrapped)
			s = dn ? s + en - st + 16'h1 : s - en + st - 16'h1;
		if (br)
			s = rev16(rev16(q.ptr & 16'hFFFE) + rev16({piv[14:0], 1'b0})) & 16'hFFFE;
		r.bitrev = br;
		r.wb_val = s;
		r.ea = q.mode inside {MBAG_INDIRECT, MBAG_POST_INC, MBAG_POST_DEC} ? q.ptr : s;
		if (br)
			r.ea = q.mode == MBAG_PRE_INC ? s : q.ptr & 16'hFFFE;
		return r;
	endfunction

	function automatic logic [63:0] key(input mbag_res_type r);
		if (!r.wb_en)
			r.wb_val = 16'h0;
		return 64'(r);
	endfunction

	// ********
	// Sequence
	// ********
	initial
	begin
		{clk, rst_n, psel, pena, pwr} = 5'h0;
		{paddr, pwdata} = 64'h0;
		{xr, xw, yq} = '0;
		{mismatches, checked, cyc} = 96'h0;
		i = $urandom(32'h46CC);
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		for (i = 0; i < 8; i++)
		begin
			apb(1'b0, 8'(i * 4), 16'h0, rd, er);
			cmp(64'({er, rd}), i == 0 ? 64'h0FFF : 64'h0);
		end
		apb(1'b0, 8'h20, 16'h0, rd, er);
		cmp(64'({er, rd}), 64'h1_0000_0000);
		// Buffer at 0x0000 is aligned to its 32 bytes, pivot is half of it
		apb(1'b1, 8'h00, 16'h02FF, rd, er);
		apb(1'b1, 8'h04, 16'h8008, rd, er);
		for (k = 0; k < 16; k++)
		begin
			@(posedge clk);
			q1 = '0;
			q1.valid = 1'b1;
			q1.wreg = 4'h2;
			q1.mode = MBAG_POST_INC;
			q1.ptr = regs[2];
			q1.delta = 16'h2;
			xw <= q1;
			@(posedge clk);
			xw.valid <= 1'b0;
			#1;
			cmp(64'(xw_o.ea), 64'({k[0], k[1], k[2], k[3], 1'b0}));
			@(posedge clk);
		end
		for (k = 0; k < 12; k++)
		begin
			ctrl = {1'($urandom), 1'($urandom), 2'b00, rsel(), rsel(), rsel()};
			piv = {1'($urandom), 15'(16'h1 << ($urandom % 5))};
			xs = 16'h0800 + 16'(k * 64);
			xe = xs + 16'h1F;
			ys = 16'h2000 + 16'(k * 128);
			ye = ys + 16'h3F;
			cfg = '{ctrl, piv, xs, xe, ys, ye};
			for (i = 0; i < 6; i++)
			begin
				apb(1'b1, 8'(i * 4), cfg[i], rd, er);
				apb(1'b0, 8'(i * 4), 16'h0, rd, er);
				cmp(64'(rd), 64'(cfg[i]));
			end
			for (i = 0; i < 60; i++)
			begin
				@(posedge clk);
				q0 = nq(xs, 1'b0);
				q1 = nq(xs, 1'b0);
				q2 = nq(ys, 1'b1);
				xr <= q0;
				xw <= q1;
				yq <= q2;
				#1;
				if (i > 0)
				begin
					cmp(key(xr_o), key(e0));
					cmp(key(xw_o), key(e1));
					cmp(key(y_o), key(e2));
				end
				e0 = ex(q0, 0);
				e1 = ex(q1, 1);
				e2 = ex(q2, 2);
			end
		end
		end_sim();
	end
endmodule
`default_nettype wire
